// *** src/t1_rx_status_interrupt.sv ***
`include "t1_rx_status_defs.svh"
module t1_rx_status_interrupt
  import t1_rx_status_pkg::*;
#(
  parameter int AIS_WINDOW = `AIS_WINDOW_BITS,
  parameter int AIS_ZEROS  = `AIS_MAX_ZEROS
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_int_n,
  input  wire logic       i_rx_clk,
  input  wire logic       i_rx_positive_rail,
  input  wire logic       i_rx_negative_rail,
  input  wire logic       i_frame_synced,
  input  wire logic       i_remote_alarm,
  input  wire logic       i_fbit_strobe,
  input  wire logic       i_fbit_error,
  input  wire logic       i_resync_done,
  input  wire logic       i_alignment_changed,
  input  wire logic       i_loopup_match,
  input  wire logic       i_loopdown_match,
  input  wire logic       i_spare_match
);
  localparam logic [7:0] LOS_LIMIT = 8'(`LOS_ZERO_COUNT);
  localparam logic [7:0] RUN_SHORT = 8'(`ZERO_RUN_SHORT - 1);
  localparam logic [7:0] RUN_LONG  = 8'(`ZERO_RUN_LONG - 1);
  localparam logic [7:0] PD_LAST   = 8'(`PD_WINDOW_BITS - 1);
  localparam logic [7:0] PD_ONES   = 8'(`PD_MIN_ONES);
  localparam logic [7:0] RX_CLOCK_LOST_NOW_MAX  = 8'(`RX_CLOCK_LOST_NOW_CYCLES);
  localparam logic [2:0] SEVERE_FRAMING_ERROR_MIN  = 3'(`SEVERE_FRAMING_ERROR_MIN_ERRORS);
  localparam logic [11:0] AIS_LAST = 12'(AIS_WINDOW - 1);
  localparam logic [11:0] AIS_LIM  = 12'(AIS_ZEROS);
  // host port strobes
  logic   rd_act;
  logic   wr_act;
  logic   wr_edge_latch;
  logic   wr_error_latch;
  logic   wr_loop_latch;
  byte_t  clr_bits;
  // line side
  logic   rx_clk_prev;
  logic   bit_tick;
  logic   pulse_now;
  logic   pol_now;
  logic   zero_now;
  logic [7:0] zero_run;
  logic   los_state;
  logic [6:0] hist_pulse;
  logic [6:0] hist_pol;
  logic   old_pol;
  logic [7:0] win_pulse;
  logic [7:0] win_pol;
  logic   b8zs_hit;
  logic [7:0] pd_count;
  logic [7:0] pd_ones;
  logic   pd_hit;
  logic [11:0] ais_count;
  logic [11:0] ais_zeros;
  logic   ais_state;
  logic [`SEVERE_FRAMING_ERROR_WINDOW-2:0] fbit_hist;
  logic [2:0] fbit_errs;
  logic [7:0] idle_count;
  // status
  alarm_s alarm_live;
  alarm_s alarm_prev;
  loop_s  loop_live;
  loop_s  loop_prev;
  byte_t  edge_set;
  byte_t  error_set;
  byte_t  loop_set;
  byte_t  rx_alarm_edge_latch;
  byte_t  rx_alarm_edge_mask;
  byte_t  rx_error_event_latch;
  byte_t  rx_loop_code_latch;
  byte_t  rx_loop_code_mask;
  byte_t  rx_irq_summary;
  byte_t  next_rdata;
  // host strobes; a held write strobe just repeats an idempotent clear
  assign rd_act         = ~i_cs_n & ~i_rd_n;
  assign wr_act         = ~i_cs_n & ~i_wr_n;
  assign wr_edge_latch  = wr_act && (i_addr == `ADDR_ALARM_EDGE_LATCH);
  assign wr_error_latch = wr_act && (i_addr == `ADDR_ERROR_EVENT_LATCH);
  assign wr_loop_latch  = wr_act && (i_addr == `ADDR_LOOP_CODE_LATCH);
  assign clr_bits       = i_wdata;  // zero bits leave their latch alone

  // receive clock is taken as synchronous: one bit per rising edge
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_clk_prev <= 1'b0;
    end else begin
      rx_clk_prev <= i_rx_clk;
    end
  end

  assign bit_tick  = i_rx_clk & ~rx_clk_prev;
  assign pulse_now = i_rx_positive_rail | i_rx_negative_rail;
  assign pol_now   = i_rx_positive_rail;
  assign zero_now  = ~pulse_now;
  // idle counter for the receive clock; saturates so it never wraps back
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      idle_count <= 8'h00;
    end else if (i_rx_clk != rx_clk_prev) begin
      idle_count <= 8'h00;
    end else if (idle_count != RX_CLOCK_LOST_NOW_MAX) begin
      idle_count <= idle_count + 8'h01;
    end
  end

  // zero-run length, saturating above the loss-of-signal limit
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      zero_run <= 8'h00;
    end else if (bit_tick) begin
      if (pulse_now) begin
        zero_run <= 8'h00;
      end else if (zero_run != 8'hFF) begin
        zero_run <= zero_run + 8'h01;
      end
    end
  end

  // loss of signal: set on the 192nd zero, cleared by the next pulse
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      los_state <= 1'b0;
    end else if (bit_tick) begin
      if (pulse_now) begin
        los_state <= 1'b0;
      end else if (zero_run == LOS_LIMIT - 8'h01) begin
        los_state <= 1'b1;
      end
    end
  end

  // symbol history for the B8ZS search; old_pol is the last pulse before it
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      hist_pulse <= 7'h00;
      hist_pol   <= 7'h00;
      old_pol    <= 1'b0;
    end else if (bit_tick) begin
      hist_pulse <= {hist_pulse[5:0], pulse_now};
      hist_pol   <= {hist_pol[5:0], pol_now};
      if (hist_pulse[6]) begin
        old_pol <= hist_pol[6];
      end
    end
  end

  // codeword 000VB0VB, oldest first; decoding mode plays no part
  assign win_pulse = {hist_pulse, pulse_now};
  assign win_pol   = {hist_pol, pol_now};
  assign b8zs_hit  = bit_tick
                  && (win_pulse == 8'b0001_1011)
                  && (win_pol[4] == old_pol)
                  && (win_pol[3] != win_pol[4])
                  && (win_pol[1] == win_pol[3])
                  && (win_pol[0] != win_pol[1]);

  // pulse density: too few ones in each block of bits
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pd_count <= 8'h00;
      pd_ones  <= 8'h00;
    end else if (bit_tick) begin
      if (pd_count == PD_LAST) begin
        pd_count <= 8'h00;
        pd_ones  <= 8'h00;
      end else begin
        pd_count <= pd_count + 8'h01;
        if (pulse_now && pd_ones != 8'hFF) begin
          pd_ones <= pd_ones + 8'h01;
        end
      end
    end
  end

  // block check plus the over-fifteen-zeros limit; block test ignores last bit
  assign pd_hit = bit_tick
               && (((pd_count == PD_LAST) && (pd_ones < PD_ONES))
                || (zero_now && (zero_run == RUN_LONG)));

  // blue alarm: few zeros per window and no frame found, so framed
  // all-ones (which the framer locks to) never raises it
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ais_count <= 12'h000;
      ais_zeros <= 12'h000;
      ais_state <= 1'b0;
    end else if (bit_tick) begin
      if (ais_count == AIS_LAST) begin
        ais_count <= 12'h000;
        ais_zeros <= 12'h000;
        ais_state <= (ais_zeros <= AIS_LIM) && !i_frame_synced;
      end else begin
        ais_count <= ais_count + 12'h001;
        if (zero_now && ais_zeros != 12'hFFF) begin
          ais_zeros <= ais_zeros + 12'h001;
        end
      end
    end
  end
  // framing-bit error history over the last six framing bits
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fbit_hist <= '0;
    end else if (i_fbit_strobe) begin
      fbit_hist <= {fbit_hist[`SEVERE_FRAMING_ERROR_WINDOW-3:0], i_fbit_error};
    end
  end
  always_comb begin
    fbit_errs = {2'b00, i_fbit_error};
    for (int k = 0; k < `SEVERE_FRAMING_ERROR_WINDOW - 1; k++) begin
      fbit_errs = fbit_errs + {2'b00, fbit_hist[k]};
    end
  end

  // present conditions, registered so a read sees a settled value
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      alarm_live <= '0;
      loop_live  <= '0;
    end else begin
      alarm_live.loss_of_frame  <= ~i_frame_synced;
      alarm_live.loss_of_signal <= los_state;
      alarm_live.blue_alarm     <= ais_state;
      alarm_live.yellow_alarm   <= i_remote_alarm;
      loop_live.loopup_code     <= i_loopup_match;
      loop_live.loopdown_code   <= i_loopdown_match;
      loop_live.spare_code      <= i_spare_match;
      loop_live.rx_clock_lost   <= (idle_count == RX_CLOCK_LOST_NOW_MAX);
    end
  end

  // previous conditions for the edge detectors
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      alarm_prev <= '0;
      loop_prev  <= '0;
    end else begin
      alarm_prev <= alarm_live;
      loop_prev  <= loop_live;
    end
  end

  // only a change of state sets a latch, so a standing alarm cannot re-set it
  assign edge_set = {~alarm_live & alarm_prev, alarm_live & ~alarm_prev};
  assign loop_set = {~loop_live & loop_prev, loop_live & ~loop_prev};
  // error events are single-cycle pulses by construction
  always_comb begin
    error_set                       = 8'h00;
    error_set[`ERR_FRAMING_BIT]     = i_fbit_strobe & i_fbit_error;
    error_set[`ERR_B8ZS_CODEWORD]   = b8zs_hit;
    error_set[`ERR_SEVERE_FRAMING]  = i_fbit_strobe & i_fbit_error
                                    & (fbit_errs >= SEVERE_FRAMING_ERROR_MIN);
    error_set[`ERR_SIXTEEN_ZERO]    = bit_tick & zero_now & (zero_run == RUN_LONG);
    error_set[`ERR_EIGHT_ZERO]      = bit_tick & zero_now & (zero_run == RUN_SHORT);
    error_set[`ERR_ALIGN_CHANGED]   = i_resync_done & i_alignment_changed;
    error_set[`ERR_PULSE_DENSITY]   = pd_hit;
  end

  // alarm edge latch: set beats a simultaneous clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_alarm_edge_latch <= `RESET_BYTE;
    end else if (wr_edge_latch) begin
      rx_alarm_edge_latch <= (rx_alarm_edge_latch & ~clr_bits) | edge_set;
    end else begin
      rx_alarm_edge_latch <= rx_alarm_edge_latch | edge_set;
    end
  end

  // error event latch, same write-one-to-clear scheme
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_error_event_latch <= `RESET_BYTE;
    end else if (wr_error_latch) begin
      rx_error_event_latch <= (rx_error_event_latch & ~clr_bits) | error_set;
    end else begin
      rx_error_event_latch <= rx_error_event_latch | error_set;
    end
  end

  // loop-code latch
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_loop_code_latch <= `RESET_BYTE;
    end else if (wr_loop_latch) begin
      rx_loop_code_latch <= (rx_loop_code_latch & ~clr_bits) | loop_set;
    end else begin
      rx_loop_code_latch <= rx_loop_code_latch | loop_set;
    end
  end

  // mask registers, all masked after reset
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_alarm_edge_mask <= `RESET_BYTE;
      rx_loop_code_mask  <= `RESET_BYTE;
    end else if (wr_act) begin
      if (i_addr == `ADDR_ALARM_EDGE_MASK) begin
        rx_alarm_edge_mask <= i_wdata;
      end else if (i_addr == `ADDR_LOOP_CODE_MASK) begin
        rx_loop_code_mask <= i_wdata;
      end
    end
  end

  // summary; the error latch has no mask and never counts
  always_comb begin
    rx_irq_summary                = 8'h00;
    rx_irq_summary[`SUM_ALARM]    = |(rx_alarm_edge_latch & rx_alarm_edge_mask);
    rx_irq_summary[`SUM_ERROR]    = 1'b0;
    rx_irq_summary[`SUM_LOOP]     = |(rx_loop_code_latch & rx_loop_code_mask);
  end

  // interrupt follows the latches, not the alarms, so it drops on clear
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_int_n <= 1'b1;
    end else begin
      o_int_n <= ~(|rx_irq_summary);
    end
  end

  // read mux; nothing here touches a latch
  always_comb begin
    next_rdata = 8'h00;
    if (i_addr == `ADDR_ALARM_LIVE) begin
      next_rdata = {4'h0, alarm_live};
    end else if (i_addr == `ADDR_ALARM_EDGE_LATCH) begin
      next_rdata = rx_alarm_edge_latch;
    end else if (i_addr == `ADDR_ALARM_EDGE_MASK) begin
      next_rdata = rx_alarm_edge_mask;
    end else if (i_addr == `ADDR_ERROR_EVENT_LATCH) begin
      next_rdata = rx_error_event_latch;
    end else if (i_addr == `ADDR_LOOP_CODE_LIVE) begin
      next_rdata = {4'h0, loop_live};
    end else if (i_addr == `ADDR_LOOP_CODE_LATCH) begin
      next_rdata = rx_loop_code_latch;
    end else if (i_addr == `ADDR_LOOP_CODE_MASK) begin
      next_rdata = rx_loop_code_mask;
    end else if (i_addr == `ADDR_IRQ_SUMMARY) begin
      next_rdata = rx_irq_summary;
    end
  end

  logic rd_prev;
  // capture at the start of a read and hold, so the byte stays stable
  // even if a condition changes while the strobe is low
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_prev <= 1'b0;
      o_rdata <= 8'h00;
    end else begin
      rd_prev <= rd_act;
      if (rd_act && !rd_prev) begin
        o_rdata <= next_rdata;
      end
    end
  end
endmodule

// *** src/t1_rx_status_defs.svh ***
`ifndef T1_RX_STATUS_DEFS_SVH
`define T1_RX_STATUS_DEFS_SVH

// register offsets on the 8-bit host port
`define ADDR_ALARM_LIVE        4'h0
`define ADDR_ALARM_EDGE_LATCH  4'h1
`define ADDR_ALARM_EDGE_MASK   4'h2
`define ADDR_ERROR_EVENT_LATCH 4'h3
`define ADDR_LOOP_CODE_LIVE    4'h4
`define ADDR_LOOP_CODE_LATCH   4'h5
`define ADDR_LOOP_CODE_MASK    4'h6
`define ADDR_IRQ_SUMMARY       4'h7

// reset values
`define RESET_BYTE             8'h00

// error event bit positions
`define ERR_FRAMING_BIT        0
`define ERR_B8ZS_CODEWORD      1
`define ERR_SEVERE_FRAMING     2
`define ERR_SIXTEEN_ZERO       3
`define ERR_EIGHT_ZERO         4
`define ERR_ALIGN_CHANGED      5
`define ERR_PULSE_DENSITY      7

// summary bit positions
`define SUM_ALARM              0
`define SUM_ERROR              1
`define SUM_LOOP               2

// line timing
`define REF_CLK_PERIOD_NS      40
`define CHANNEL_TIME_NS        5181
`define RX_CLOCK_LOST_NOW_CYCLES            ((`CHANNEL_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define LOS_ZERO_COUNT         192
`define ZERO_RUN_SHORT         8
`define ZERO_RUN_LONG          16
`define SEVERE_FRAMING_ERROR_WINDOW            6
`define SEVERE_FRAMING_ERROR_MIN_ERRORS        2
`define PD_WINDOW_BITS         192
`define PD_MIN_ONES            24
`define AIS_WINDOW_BITS        2048
`define AIS_MAX_ZEROS          8

`endif

// *** src/t1_rx_status_pkg.sv ***
package t1_rx_status_pkg;

  // the four line alarms, bit 3 down to bit 0
  typedef struct packed {
    logic yellow_alarm;
    logic blue_alarm;
    logic loss_of_signal;
    logic loss_of_frame;
  } alarm_s;

  // the loop-code conditions, bit 3 down to bit 0
  typedef struct packed {
    logic rx_clock_lost;
    logic spare_code;
    logic loopdown_code;
    logic loopup_code;
  } loop_s;

  typedef logic [7:0] byte_t;

endpackage

// *** bench/t1_rx_status_interrupt_props.sv ***
`include "t1_rx_status_defs.svh"

module t1_rx_status_interrupt_props
  import t1_rx_status_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_cs_n,
  input  wire logic       i_rd_n,
  input  wire logic       i_wr_n,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic [7:0] o_rdata,
  input  wire logic       o_int_n,
  input  wire logic       i_frame_synced,
  input  wire logic       i_remote_alarm,
  input  wire logic       i_loopup_match
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  logic rd_prev;
  logic mask_seen;
  logic rd_start;
  logic wr_any;
  assign rd_start = !i_cs_n && !i_rd_n && !rd_prev;
  assign wr_any   = !i_cs_n && !i_wr_n;

  // a read is taken only on its first cycle, so track the previous strobe
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) rd_prev <= 1'b0;
    else rd_prev <= !i_cs_n && !i_rd_n;
  end

  // until some mask bit is written to one nothing may reach the interrupt
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) mask_seen <= 1'b0;
    else if (wr_any && (i_addr == `ADDR_ALARM_EDGE_MASK || i_addr == `ADDR_LOOP_CODE_MASK)
             && i_wdata != 8'h00) mask_seen <= 1'b1;
  end

  property p_rdata_hold;
    !rd_start |=> $stable(o_rdata);
  endproperty
  property p_int_masked;
    !mask_seen |-> o_int_n;
  endproperty
  property p_int_rise;
    $rose(o_int_n) |-> $past(wr_any, 1) || $past(wr_any, 2);
  endproperty
  property p_lof_live;
    (!i_frame_synced) [*3] ##0 (rd_start && i_addr == `ADDR_ALARM_LIVE) |=> o_rdata[0];
  endproperty
  property p_yellow_live;
    i_remote_alarm [*3] ##0 (rd_start && i_addr == `ADDR_ALARM_LIVE) |=> o_rdata[3];
  endproperty
  property p_loopup_live;
    i_loopup_match [*3] ##0 (rd_start && i_addr == `ADDR_LOOP_CODE_LIVE) |=> o_rdata[0];
  endproperty
  property p_live_upper;
    rd_start && (i_addr == `ADDR_ALARM_LIVE || i_addr == `ADDR_LOOP_CODE_LIVE)
      |=> o_rdata[7:4] == 4'h0;
  endproperty
  property p_err_bit6;
    rd_start && i_addr == `ADDR_ERROR_EVENT_LATCH |=> !o_rdata[6];
  endproperty
  property p_sum_err;
    rd_start && i_addr == `ADDR_IRQ_SUMMARY |=> !o_rdata[`SUM_ERROR];
  endproperty

  a_rdata_hold  : assert property (p_rdata_hold)  else $error("read data moved without a read");
  a_int_masked  : assert property (p_int_masked)  else $error("interrupt with all masks zero");
  a_int_rise    : assert property (p_int_rise)    else $error("interrupt released without a write");
  a_lof_live    : assert property (p_lof_live)    else $error("loss of frame not shown live");
  a_yellow_live : assert property (p_yellow_live) else $error("remote alarm not shown live");
  a_loopup_live : assert property (p_loopup_live) else $error("loop-up not shown live");
  a_live_upper  : assert property (p_live_upper)  else $error("unused live bits not zero");
  a_err_bit6    : assert property (p_err_bit6)    else $error("unused error bit set");
  a_sum_err     : assert property (p_sum_err)     else $error("error latch in summary");

  c_int_low  : cover property (!o_int_n);
  c_int_rise : cover property ($rose(o_int_n));
  c_rd_latch : cover property (rd_start && i_addr == `ADDR_ALARM_EDGE_LATCH);
endmodule

bind t1_rx_status_interrupt t1_rx_status_interrupt_props chk_u (
  .i_ref_clk, .i_rst, .i_cs_n, .i_rd_n, .i_wr_n, .i_addr, .i_wdata, .o_rdata, .o_int_n,
  .i_frame_synced, .i_remote_alarm, .i_loopup_match
);

// *** bench/t1_line_model.sv ***
module t1_line_model (
  input  wire logic i_ref_clk,
  input  wire logic i_en,
  input  wire logic i_ones,
  input  wire logic i_b8zs,
  output logic      o_rx_clk,
  output logic      o_pos,
  output logic      o_neg
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] phase;
  logic       pol;
  logic [2:0] sym;
  logic       cw_mark;
  logic       cw_pos;

  // codeword 000VB0VB: marks at symbols 3,4,6,7; V repeats the last mark's sign
  assign cw_mark = (sym == 3'h3) || (sym == 3'h4) || (sym[2:1] == 2'b11);
  assign cw_pos  = pol ^ ((sym == 3'h4) || (sym == 3'h6));

  initial begin
    phase    = 2'h0;
    sym      = 3'h0;
    pol      = 1'b0;
    o_rx_clk = 1'b0;
    o_pos    = 1'b0;
    o_neg    = 1'b0;
  end

  // one bit every four reference cycles; marks alternate rails as ami does
  always @(posedge i_ref_clk) begin
    if (!i_en) begin
      // clock stands still; rails wander so a stale level never looks like data
      o_pos <= ~o_pos;
      o_neg <= o_pos;
    end else begin
      phase <= phase + 2'h1;
      if (phase == 2'h0) begin
        o_rx_clk <= 1'b0;
        if (i_b8zs) begin
          // pol is left alone so ami carries on against the codeword's last mark
          o_pos <= cw_mark & cw_pos;
          o_neg <= cw_mark & ~cw_pos;
          sym   <= sym + 3'h1;
        end else begin
          o_pos <= i_ones & ~pol;
          o_neg <= i_ones & pol;
          pol   <= pol ^ i_ones;
        end
      end else if (phase == 2'h2) begin
        o_rx_clk <= 1'b1;
      end
    end
  end
endmodule

// *** bench/t1_rx_status_interrupt_bench.sv ***
`include "t1_rx_status_defs.svh"

module t1_rx_status_interrupt_bench
  import t1_rx_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk, rst, cs_n, rd_n, wr_n, fsync, ralarm, fstb, ferr, rsdone, achg;
  logic       loopup_code_now, loopdown_code_now, spare_code_now, l_en, l_ones, int_n, rx_clk, pos, neg, b8zs;
  logic [3:0] addr;
  byte_t      wdata, rdata;
  int         mismatches, cmp_count;

  // short blue-alarm window keeps the run brief
  t1_rx_status_interrupt #(.AIS_WINDOW(64), .AIS_ZEROS(2)) dut_u (
    .i_ref_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .o_int_n(int_n), .i_rx_clk(rx_clk),
    .i_rx_positive_rail(pos), .i_rx_negative_rail(neg), .i_frame_synced(fsync),
    .i_remote_alarm(ralarm), .i_fbit_strobe(fstb), .i_fbit_error(ferr),
    .i_resync_done(rsdone), .i_alignment_changed(achg), .i_loopup_match(loopup_code_now),
    .i_loopdown_match(loopdown_code_now), .i_spare_match(spare_code_now)
  );

  t1_line_model line_u (
    .i_ref_clk(clk), .i_en(l_en), .i_ones(l_ones), .i_b8zs(b8zs),
    .o_rx_clk(rx_clk), .o_pos(pos), .o_neg(neg)
  );

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // every drive lands 5 ns after a rising edge
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic wr(input logic [3:0] a, input byte_t d);
    cs_n = 1'b0; wr_n = 1'b0; addr = a; wdata = d;
    wt(1);
    cs_n = 1'b1; wr_n = 1'b1;
    wt(1);
  endtask
  // strobes drop for a cycle after each access so the next read is a new one
  task automatic rd(input logic [3:0] a, output byte_t d);
    cs_n = 1'b0; rd_n = 1'b0; addr = a;
    wt(1);
    cs_n = 1'b1; rd_n = 1'b1; d = rdata;
    wt(1);
  endtask
  task automatic chk(input byte_t got, input byte_t exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [3:0] a, input byte_t m, input byte_t e);
    byte_t d;
    rd(a, d);
    chk(d & m, e);
  endtask
  task automatic ci(input logic e);
    chk({7'h00, int_n}, {7'h00, e});
  endtask
  task automatic fb(input logic e);
    fstb = 1'b1; ferr = e;
    wt(1);
    fstb = 1'b0; ferr = 1'b0;
    wt(1);
  endtask
  task automatic resync(input logic c);
    rsdone = 1'b1; achg = c;
    wt(1);
    rsdone = 1'b0; achg = 1'b0;
    wt(1);
  endtask
  task automatic test_done();
    if (mismatches == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // watchdog sized well beyond the few thousand cycles the sequence needs
  initial begin
    #(40 * 20000);
    mismatches++;
    test_done();
  end

  initial begin
    rst = 1'b1; cs_n = 1'b1; rd_n = 1'b1; wr_n = 1'b1; addr = 4'h0; wdata = 8'h00;
    fsync = 1'b1; ralarm = 1'b0; fstb = 1'b0; ferr = 1'b0; rsdone = 1'b0; achg = 1'b0;
    loopup_code_now = 1'b0; loopdown_code_now = 1'b0; spare_code_now = 1'b0; l_en = 1'b1; l_ones = 1'b1; b8zs = 1'b0;
    mismatches = 0; cmp_count = 0;
    repeat (20) @(posedge clk);
    #5 rst = 1'b0;
    for (int a = 0; a < 16; a++) rc(4'(a), 8'hFF, 8'h00);
    wr(4'h9, 8'hFF);
    rc(4'h9, 8'hFF, 8'h00);
    wr(`ADDR_ALARM_LIVE, 8'hFF);
    rc(`ADDR_ALARM_LIVE, 8'hFF, 8'h00);
    wr(`ADDR_ALARM_EDGE_MASK, 8'hA5);
    rc(`ADDR_ALARM_EDGE_MASK, 8'hFF, 8'hA5);
    wr(`ADDR_ALARM_EDGE_MASK, 8'h00);
    // loss of frame: latch, mask, clear while the alarm persists
    fsync = 1'b0;
    wt(4);
    rc(`ADDR_ALARM_LIVE, 8'hFF, 8'h01);
    rc(`ADDR_ALARM_EDGE_LATCH, 8'hFF, 8'h01);
    ci(1'b1);
    wr(`ADDR_ALARM_EDGE_MASK, 8'h01);
    wt(2);
    ci(1'b0);
    rc(`ADDR_IRQ_SUMMARY, 8'h05, 8'h01);
    wr(`ADDR_ALARM_EDGE_LATCH, 8'h00);
    rc(`ADDR_ALARM_EDGE_LATCH, 8'hFF, 8'h01);
    wr(`ADDR_ALARM_EDGE_LATCH, 8'h01);
    wt(2);
    ci(1'b1);
    rc(`ADDR_IRQ_SUMMARY, 8'h05, 8'h00);
    wt(10);
    rc(`ADDR_ALARM_EDGE_LATCH, 8'hFF, 8'h00);
    fsync = 1'b1;
    wt(4);
    rc(`ADDR_ALARM_EDGE_LATCH, 8'hFF, 8'h10);
    ci(1'b1);
    ralarm = 1'b1;
    wt(4);
    rc(`ADDR_ALARM_LIVE, 8'hFF, 8'h08);
    ralarm = 1'b0;
    wt(4);
    rc(`ADDR_ALARM_EDGE_LATCH, 8'hFF, 8'h98);
    wr(`ADDR_ALARM_EDGE_LATCH, 8'hFF);
    // each loop code raised and dropped in turn, all unmasked
    wr(`ADDR_LOOP_CODE_MASK, 8'hFF);
    for (int i = 0; i < 3; i++) begin
      {spare_code_now, loopdown_code_now, loopup_code_now} = 3'(1 << i);
      wt(4);
      rc(`ADDR_LOOP_CODE_LIVE, 8'hFF, 8'(1 << i));
      ci(1'b0);
      {spare_code_now, loopdown_code_now, loopup_code_now} = 3'h0;
      wt(4);
      rc(`ADDR_LOOP_CODE_LATCH, 8'hFF, 8'(8'h11 << i));
      wr(`ADDR_LOOP_CODE_LATCH, 8'hFF);
      wt(2);
      ci(1'b1);
    end
    // receive clock stops for longer than a channel time
    l_en = 1'b0;
    wt(140);
    rc(`ADDR_LOOP_CODE_LIVE, 8'hFF, 8'h08);
    l_en = 1'b1;
    wt(10);
    rc(`ADDR_LOOP_CODE_LATCH, 8'hFF, 8'h88);
    wr(`ADDR_LOOP_CODE_LATCH, 8'hFF);
    wr(`ADDR_LOOP_CODE_MASK, 8'h00);
    // zero runs: a short one, then one long enough for loss of signal
    wr(`ADDR_ERROR_EVENT_LATCH, 8'hFF);
    l_ones = 1'b0;
    wt(40);
    l_ones = 1'b1;
    wt(12);
    rc(`ADDR_ERROR_EVENT_LATCH, 8'h18, 8'h10);
    wr(`ADDR_ERROR_EVENT_LATCH, 8'hFF);
    l_ones = 1'b0;
    wt(800);
    rc(`ADDR_ALARM_LIVE, 8'h02, 8'h02);
    rc(`ADDR_ERROR_EVENT_LATCH, 8'h98, 8'h98);
    l_ones = 1'b1;
    wt(12);
    rc(`ADDR_ALARM_EDGE_LATCH, 8'h22, 8'h22);
    wr(`ADDR_ALARM_EDGE_LATCH, 8'hFF);
    wr(`ADDR_ERROR_EVENT_LATCH, 8'hFF);
    // framing bit errors: one alone, then two within six
    fb(1'b1);
    rc(`ADDR_ERROR_EVENT_LATCH, 8'h05, 8'h01);
    fb(1'b0);
    fb(1'b1);
    rc(`ADDR_ERROR_EVENT_LATCH, 8'h05, 8'h05);
    resync(1'b0);
    rc(`ADDR_ERROR_EVENT_LATCH, 8'h22, 8'h00);
    resync(1'b1);
    rc(`ADDR_ERROR_EVENT_LATCH, 8'h20, 8'h20);
    ci(1'b1);
    // one codeword in the ones stream: 32 cycles hold it for exactly eight symbols
    wr(`ADDR_ERROR_EVENT_LATCH, 8'hFF);
    b8zs = 1'b1;
    wt(32);
    b8zs = 1'b0;
    wt(12);
    rc(`ADDR_ERROR_EVENT_LATCH, 8'h12, 8'h02);
    // unframed ones with one stray zero raise blue alarm; framed ones do not
    fsync = 1'b0;
    l_ones = 1'b0;
    wt(4);
    l_ones = 1'b1;
    wt(596);
    rc(`ADDR_ALARM_LIVE, 8'h07, 8'h05);
    fsync = 1'b1;
    wt(600);
    rc(`ADDR_ALARM_LIVE, 8'h07, 8'h00);
    test_done();
  end
endmodule
